// >>> logic/iabx_datapath.sv
// Combinational adder and branch-decision datapath
`timescale 1ns/100ps
`default_nettype none
module iabx_datapath
    import iabx_pkg::*;
(
    input  wire iabx_op_t          i_op,
    input  wire logic [DATA_W-1:0] i_rs,
    input  wire logic [DATA_W-1:0] i_rt_val,
    input  wire logic [REG_IDX_W-1:0] i_rs_idx,
    input  wire logic [REG_IDX_W-1:0] i_rt_idx,
    input  wire logic [DATA_W-1:0] i_imm,
    input  wire logic [DATA_W-1:0] i_offset,
    input  wire logic [DATA_W-1:0] i_pc,
    input  wire logic [COND_W-1:0] i_condition_select_field,
    input  wire logic [COND_CNT-1:0] i_cop_flags,
    iabx_res_if.src                 res
);

    logic [DATA_W-1:0] sum_rs;      // Source plus immediate
    logic              ovf;         // Signed overflow of that sum
    logic              cop_flag;    // Selected condition flag

    // Adder, flag select and per-operation result
    always_comb
    begin
        sum_rs       = i_rs + i_imm;                                    // [RQ1]
        ovf          = (i_rs[DATA_W-1] == i_imm[DATA_W-1]) &&
                       (sum_rs[DATA_W-1] != i_rs[DATA_W-1]);
        cop_flag     = i_cop_flags[i_condition_select_field];           // [RQ5]
        res.wr_en    = 1'b0;
        res.wr_idx   = i_rt_idx;
        res.wr_data  = sum_rs;
        res.taken    = 1'b0;
        res.target   = i_pc + i_offset;
        res.nullify  = 1'b0;
        res.overflow = 1'b0;
        case (i_op)
            OP_ADD_IMM_NONTRAP:
            begin
                res.wr_en = 1'b1;                                       // [RQ1] [RQ9]
            end
            OP_ADD_IMM_TRAP:
            begin
                // Overflow traps and leaves the target untouched
                res.wr_en    = !ovf;                                    // [RQ9]
                res.overflow = ovf;                                     // [RQ9]
            end
            OP_PC_RELATIVE_ADD_IMM:
            begin
                res.wr_en   = 1'b1;
                res.wr_data = i_pc + i_imm;                             // [RQ2]
            end
            OP_BRANCH_IF_EQUAL:
            begin
                // Equal operands; r0 against r0 always takes
                res.taken = (i_rs_idx == ZERO_REG && i_rt_idx == ZERO_REG) ||
                            (i_rs == i_rt_val);                         // [RQ3]
            end
            OP_BRANCH_NONNEG_LINK:
            begin
                // Link written regardless of outcome
                res.wr_en   = 1'b1;
                res.wr_idx  = LINK_REG;                                 // [RQ4]
                res.wr_data = i_pc + LINK_OFFSET;                       // [RQ4]
                res.taken   = (i_rs_idx == ZERO_REG) || !i_rs[DATA_W-1];
            end
            OP_COP_BRANCH_FALSE:
            begin
                res.taken = !cop_flag;                                  // [RQ5]
            end
            OP_COP_BRANCH_TRUE:
            begin
                res.taken = cop_flag;                                   // [RQ5]
            end
            OP_COP_BRANCH_FALSE_LIKELY:
            begin
                res.taken   = !cop_flag;                                // [RQ6]
                res.nullify = cop_flag;                                 // [RQ6]
            end
            OP_COP_BRANCH_TRUE_LIKELY:
            begin
                res.taken   = cop_flag;                                 // [RQ6]
                res.nullify = !cop_flag;                                // [RQ6]
            end
            default:
            begin
                res.wr_en = 1'b0;
            end
        endcase
    end

endmodule // iabx_datapath
`default_nettype wire

// >>> logic/iabx_exec.sv
// Top of the add and branch execute stage with registered results
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// [RQ1] Unsigned add-immediate writes wrapping sum, no trap
// [RQ2] PC-relative add writes PC plus immediate
// [RQ3] Unconditional branch: equal compare r0 always taken
// [RQ4] Link branch writes PC+8 to r31
// [RQ5] Coprocessor branch tests selected flag, false/true
// [RQ6] Likely forms nullify next when not taken
// [RQ7] Register set count fixed; highest set readable
// [RQ8] Presence flags set only when block attached
// [RQ9] Signed add overflow traps, target unchanged
module iabx_exec
    import iabx_pkg::*;
(
    input  wire logic                 i_clock,        // Core clock
    input  wire logic                 i_srst,         // Synchronous reset
    input  wire logic                 i_clk_en,       // Freezes state when low
    input  wire logic                 i_valid,        // Instruction present
    input  wire iabx_op_t             i_op,           // Operation select
    input  wire logic [DATA_W-1:0]    i_rs,           // Source value
    input  wire logic [DATA_W-1:0]    i_rt_val,       // Second source value
    input  wire logic [REG_IDX_W-1:0] i_rs_idx,       // Source index
    input  wire logic [REG_IDX_W-1:0] i_rt_idx,       // Target / second index
    input  wire logic [DATA_W-1:0]    i_imm,          // Extended immediate
    input  wire logic [DATA_W-1:0]    i_offset,       // Signed branch offset
    input  wire logic [DATA_W-1:0]    i_pc,           // Current PC
    input  wire logic [COND_W-1:0]    i_condition_select_field, // Condition select field
    input  wire logic [COND_CNT-1:0]  i_cop_flags,    // Coprocessor condition flags
    input  wire logic                 i_cop_attached, // Coprocessor block fitted
    input  wire logic                 i_user_attached, // User-instruction block fitted
    output logic                      o_wr_en,        // Register write strobe
    output logic [REG_IDX_W-1:0]      o_wr_idx,       // Register write index
    output logic [DATA_W-1:0]         o_wr_data,      // Register write data
    output logic                      o_taken,        // Branch taken pulse
    output logic [DATA_W-1:0]         o_target,       // Branch target
    output logic                      o_nullify,      // Kill next instruction
    output logic                      o_overflow,     // Overflow exception
    output logic [SHADOW_W-1:0]       o_highest_shadow_set,    // Highest set number
    output logic                      o_coproc_present_flag,   // Coprocessor present
    output logic                      o_user_instr_present_flag // User block present
);

    iabx_res_if res ();  // Datapath result bundle

    // Datapath instance
    iabx_datapath u_dp
    (
        .i_op        (i_op),
        .i_rs        (i_rs),
        .i_rt_val    (i_rt_val),
        .i_rs_idx    (i_rs_idx),
        .i_rt_idx    (i_rt_idx),
        .i_imm       (i_imm),
        .i_offset    (i_offset),
        .i_pc        (i_pc),
        .i_condition_select_field (i_condition_select_field),
        .i_cop_flags (i_cop_flags),
        .res         (res)
    );

    logic                 wr_en_reg,    wr_en_next;     // Write strobe
    logic [REG_IDX_W-1:0] wr_idx_reg,   wr_idx_next;    // Write index
    logic [DATA_W-1:0]    wr_data_reg,  wr_data_next;   // Write data
    logic                 taken_reg,    taken_next;     // Taken strobe
    logic [DATA_W-1:0]    target_reg,   target_next;    // Target
    logic                 null_reg,     null_next;      // Nullify strobe
    logic                 ovf_reg,      ovf_next;       // Overflow strobe
    logic [SHADOW_W-1:0]  top_set_reg,  top_set_next;   // Highest set
    logic                 coproc_reg,   coproc_next;    // Coprocessor flag
    logic                 user_reg,     user_next;      // User block flag

    // Next values for results and configuration flags
    always_comb
    begin
        wr_en_next   = i_valid && res.wr_en;
        wr_idx_next  = res.wr_idx;
        wr_data_next = res.wr_data;
        taken_next   = i_valid && res.taken;
        target_next  = res.target;                                      // [RQ3]
        null_next    = i_valid && res.nullify;                          // [RQ6]
        ovf_next     = i_valid && res.overflow;                         // [RQ9]
        top_set_next = TOP_SET_VALUE;                                   // [RQ7]
        coproc_next  = i_cop_attached;                                  // [RQ8]
        user_next    = i_user_attached;                                 // [RQ8]
    end

    // Result registers, held while the enable is low
    always_ff @(posedge i_clock)
    begin
        if (i_srst)
        begin
            wr_en_reg   <= 1'b0;
            wr_idx_reg  <= ZERO_REG;
            wr_data_reg <= DATA_RESET;
            taken_reg   <= 1'b0;
            target_reg  <= DATA_RESET;
            null_reg    <= 1'b0;
            ovf_reg     <= 1'b0;
            top_set_reg <= 4'h0;
            coproc_reg  <= 1'b0;
            user_reg    <= 1'b0;
        end
        else if (i_clk_en)
        begin
            wr_en_reg   <= wr_en_next;
            wr_idx_reg  <= wr_idx_next;
            wr_data_reg <= wr_data_next;
            taken_reg   <= taken_next;
            target_reg  <= target_next;
            null_reg    <= null_next;
            ovf_reg     <= ovf_next;
            top_set_reg <= top_set_next;
            coproc_reg  <= coproc_next;
            user_reg    <= user_next;
        end
    end

    assign o_wr_en                   = wr_en_reg;
    assign o_wr_idx                  = wr_idx_reg;
    assign o_wr_data                 = wr_data_reg;
    assign o_taken                   = taken_reg;
    assign o_target                  = target_reg;
    assign o_nullify                 = null_reg;
    assign o_overflow                = ovf_reg;
    assign o_highest_shadow_set      = top_set_reg;
    assign o_coproc_present_flag     = coproc_reg;
    assign o_user_instr_present_flag = user_reg;

endmodule // iabx_exec
`default_nettype wire

// >>> logic/iabx_pkg.sv
// Package of constants and types for the add and branch execution block
package iabx_pkg;

    // Operation selects presented by the decoder
    typedef enum logic [3:0]
    {
        OP_NONE,
        OP_ADD_IMM_NONTRAP,
        OP_ADD_IMM_TRAP,
        OP_PC_RELATIVE_ADD_IMM,
        OP_BRANCH_IF_EQUAL,
        OP_BRANCH_NONNEG_LINK,
        OP_COP_BRANCH_FALSE,
        OP_COP_BRANCH_TRUE,
        OP_COP_BRANCH_FALSE_LIKELY,
        OP_COP_BRANCH_TRUE_LIKELY
    } iabx_op_t;

    localparam int          DATA_W        = 32;
    localparam int          REG_IDX_W     = 5;
    localparam int          COND_W        = 3;
    localparam int          COND_CNT      = 8;
    localparam int          SHADOW_W      = 4;
    localparam logic [4:0]  LINK_REG      = 5'h1f;
    localparam logic [4:0]  ZERO_REG      = 5'h00;
    localparam logic [31:0] LINK_OFFSET   = 32'h0000_0008;
    localparam logic [31:0] DATA_RESET    = 32'h0000_0000;
    // Register file sets built in: 1, 2, 4 or 8
    localparam int          REG_SETS      = 1;
    localparam logic [3:0]  TOP_SET_VALUE = 4'(REG_SETS - 1);
    // Field positions within the readable words
    localparam int          TOP_SET_LSB   = 26;
    localparam int          COPROC_BIT    = 6;
    localparam int          USER_INSTR_BIT = 22;

endpackage : iabx_pkg

// >>> logic/iabx_res_if.sv
// Interface carrying one execute result between the datapath and its register stage
`timescale 1ns/100ps
`default_nettype none
interface iabx_res_if;
    import iabx_pkg::*;
    logic                 wr_en;     // Register write requested
    logic [REG_IDX_W-1:0] wr_idx;    // Target register
    logic [DATA_W-1:0]    wr_data;   // Write value
    logic                 taken;     // Branch taken
    logic [DATA_W-1:0]    target;    // Branch target
    logic                 nullify;   // Kill next instruction
    logic                 overflow;  // Overflow exception

    modport src (output wr_en, wr_idx, wr_data, taken, target, nullify, overflow);
    modport dst (input  wr_en, wr_idx, wr_data, taken, target, nullify, overflow);
endinterface : iabx_res_if
`default_nettype wire

// >>> test/iabx_exec_props.sv
// Concurrent checks on the add and branch execute stage ports
`timescale 1ns/100ps
`default_nettype none
module iabx_exec_props
    import iabx_pkg::*;
(
    input wire logic        i_clock,
    input wire logic        i_srst,
    input wire logic        i_clk_en,
    input wire logic        i_valid,
    input wire iabx_op_t    i_op,
    input wire logic [31:0] i_rs,
    input wire logic [31:0] i_rt_val,
    input wire logic [4:0]  i_rs_idx,
    input wire logic [4:0]  i_rt_idx,
    input wire logic [31:0] i_imm,
    input wire logic [31:0] i_offset,
    input wire logic [31:0] i_pc,
    input wire logic [2:0]  i_condition_select_field,
    input wire logic [7:0]  i_cop_flags,
    input wire logic        i_cop_attached,
    input wire logic        i_user_attached,
    input wire logic        o_wr_en,
    input wire logic [4:0]  o_wr_idx,
    input wire logic [31:0] o_wr_data,
    input wire logic        o_taken,
    input wire logic [31:0] o_target,
    input wire logic        o_nullify,
    input wire logic        o_overflow,
    input wire logic [3:0]  o_highest_shadow_set,
    input wire logic        o_coproc_present_flag,
    input wire logic        o_user_instr_present_flag
);
    // Selected flag, sum and signed overflow of the sum
    wire logic        sel_flag = i_cop_flags[i_condition_select_field];
    wire logic [31:0] sum      = i_rs + i_imm;
    wire logic        ovf_in   = (i_rs[31] == i_imm[31]) && (sum[31] != i_rs[31]);

    default clocking @(posedge i_clock); endclocking
    default disable iff (i_srst);

    // Instruction of one kind taken at this edge
    sequence s_issue(iabx_op_t op);
        i_clk_en && i_valid && i_op == op;
    endsequence

    property p_add;
        s_issue(OP_ADD_IMM_NONTRAP) |=> o_wr_en && !o_overflow && o_wr_idx == $past(i_rt_idx)
            && o_wr_data == $past(i_rs) + $past(i_imm);
    endproperty
    a_add: assert property (p_add) else $error("wrapping add wrong");
    property p_pc_add;
        s_issue(OP_PC_RELATIVE_ADD_IMM) |=> o_wr_en && o_wr_data == $past(i_pc) + $past(i_imm);
    endproperty
    a_pc_add: assert property (p_pc_add) else $error("pc add wrong");
    property p_equal;
        s_issue(OP_BRANCH_IF_EQUAL) ##0 i_rs == i_rt_val
            |=> o_taken && o_target == $past(i_pc) + $past(i_offset);
    endproperty
    a_equal: assert property (p_equal) else $error("equal branch wrong");
    property p_link;
        s_issue(OP_BRANCH_NONNEG_LINK) ##0 i_rs_idx == ZERO_REG |=> o_taken && o_wr_en
            && o_wr_idx == LINK_REG && o_wr_data == $past(i_pc) + LINK_OFFSET;
    endproperty
    a_link: assert property (p_link) else $error("link branch wrong");
    property p_cop_f;
        s_issue(OP_COP_BRANCH_FALSE) |=> o_taken == !$past(sel_flag) && !o_nullify;
    endproperty
    a_cop_f: assert property (p_cop_f) else $error("false branch wrong");
    property p_cop_t;
        s_issue(OP_COP_BRANCH_TRUE) |=> o_taken == $past(sel_flag) && !o_nullify;
    endproperty
    a_cop_t: assert property (p_cop_t) else $error("true branch wrong");
    property p_likely;
        s_issue(OP_COP_BRANCH_TRUE_LIKELY) ##0 !sel_flag |=> !o_taken && o_nullify;
    endproperty
    a_likely: assert property (p_likely) else $error("likely kill wrong");
    property p_likely_f;
        s_issue(OP_COP_BRANCH_FALSE_LIKELY) ##0 sel_flag |=> !o_taken && o_nullify;
    endproperty
    a_likely_f: assert property (p_likely_f) else $error("false likely kill wrong");
    property p_trap;
        s_issue(OP_ADD_IMM_TRAP) ##0 ovf_in |=> o_overflow && !o_wr_en;
    endproperty
    a_trap: assert property (p_trap) else $error("overflow trap wrong");
    property p_shadow;
        i_clk_en |=> o_highest_shadow_set == TOP_SET_VALUE;
    endproperty
    a_shadow: assert property (p_shadow) else $error("shadow set wrong");
    property p_fit;
        i_clk_en |=> o_coproc_present_flag == $past(i_cop_attached)
            && o_user_instr_present_flag == $past(i_user_attached);
    endproperty
    a_fit: assert property (p_fit) else $error("presence flag wrong");
endmodule // iabx_exec_props

bind iabx_exec iabx_exec_props u_props (.i_clock, .i_srst, .i_clk_en, .i_valid, .i_op, .i_rs,
    .i_rt_val, .i_rs_idx, .i_rt_idx, .i_imm, .i_offset, .i_pc, .i_condition_select_field,
    .i_cop_flags, .i_cop_attached, .i_user_attached, .o_wr_en, .o_wr_idx, .o_wr_data, .o_taken,
    .o_target,
    .o_nullify, .o_overflow, .o_highest_shadow_set, .o_coproc_present_flag,
    .o_user_instr_present_flag);
`default_nettype wire

// >>> test/tb_iabx_exec.sv
// Random and corner test of the add and branch execute stage
`timescale 1ns/100ps
`default_nettype none
module tb_iabx_exec;
    import iabx_pkg::*;
    logic        i_clock = 1'b0, i_srst = 1'b1, i_clk_en = 1'b0, i_valid = 1'b0;
    iabx_op_t    i_op = OP_NONE;
    logic [31:0] i_rs = '0, i_rt_val = '0, i_imm = '0, i_offset = '0, i_pc = '0;
    logic [4:0]  i_rs_idx = '0, i_rt_idx = '0;
    logic [2:0]  i_condition_select_field = '0;
    logic [7:0]  i_cop_flags = '0;
    logic        i_cop_attached = 1'b0, i_user_attached = 1'b0;
    logic        o_wr_en, o_taken, o_nullify, o_overflow;
    logic        o_coproc_present_flag, o_user_instr_present_flag;
    logic [4:0]  o_wr_idx;
    logic [31:0] o_wr_data, o_target;
    logic [3:0]  o_highest_shadow_set;
    int          n_errors = 0, check_count = 0;
    // Expected outputs after the latest edge
    logic        e_wr = 1'b0, e_ovf = 1'b0, e_taken = 1'b0, e_null = 1'b0;
    logic        e_cop = 1'b0, e_user = 1'b0;
    logic [4:0]  e_idx = '0;
    logic [31:0] e_data = '0, e_tgt = '0;
    logic [3:0]  e_shadow = '0;
    // Corner cases: overflow both ways, carry out, wrap, link, equal on r0
    iabx_op_t    c_op[6] = '{OP_ADD_IMM_TRAP, OP_ADD_IMM_TRAP, OP_ADD_IMM_TRAP,
                             OP_ADD_IMM_NONTRAP, OP_BRANCH_NONNEG_LINK, OP_BRANCH_IF_EQUAL};
    logic [31:0] c_rs[6] = '{32'h7fffffff, 32'h80000000, 32'hffffffff, 32'hffffffff, '0, '0};
    logic [31:0] c_imm[6] = '{32'h00000001, 32'h80000000, 32'h00000001, 32'h00000002, '0, '0};

    iabx_exec dut_u (.i_clock, .i_srst, .i_clk_en, .i_valid, .i_op, .i_rs, .i_rt_val, .i_rs_idx,
        .i_rt_idx, .i_imm, .i_offset, .i_pc, .i_condition_select_field, .i_cop_flags,
        .i_cop_attached, .i_user_attached, .o_wr_en, .o_wr_idx, .o_wr_data, .o_taken,
        .o_target, .o_nullify, .o_overflow, .o_highest_shadow_set, .o_coproc_present_flag,
        .o_user_instr_present_flag);

    // Clock of 5 ns
    always #2.5 i_clock = ~i_clock;

    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        check_count++;
        if (seen !== want)
        begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    // Counts, verdict and end of run
    task automatic finish_test();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Registered result of the instruction sampled at the last edge
    function automatic void predict();
        logic [31:0] sum;
        logic        ovf, flag, tk;
        sum = i_rs + i_imm;
        ovf = (i_rs[31] == i_imm[31]) && (sum[31] != i_rs[31]);
        flag = i_cop_flags[i_condition_select_field];
        tk = 1'b0;
        e_idx = i_rt_idx;
        e_data = sum;
        e_tgt = i_pc + i_offset;
        case (i_op)
            OP_PC_RELATIVE_ADD_IMM: e_data = i_pc + i_imm;
            OP_BRANCH_IF_EQUAL: tk = (i_rs == i_rt_val);
            OP_BRANCH_NONNEG_LINK:
            begin
                tk = (i_rs_idx == ZERO_REG) || !i_rs[31];
                e_idx = LINK_REG;
                e_data = i_pc + LINK_OFFSET;
            end
            OP_COP_BRANCH_FALSE, OP_COP_BRANCH_FALSE_LIKELY: tk = !flag;
            OP_COP_BRANCH_TRUE, OP_COP_BRANCH_TRUE_LIKELY: tk = flag;
            default: tk = 1'b0;
        endcase
        e_ovf = i_valid && i_op == OP_ADD_IMM_TRAP && ovf;
        e_wr = i_valid && (i_op inside {OP_ADD_IMM_NONTRAP, OP_PC_RELATIVE_ADD_IMM,
            OP_BRANCH_NONNEG_LINK} || (i_op == OP_ADD_IMM_TRAP && !ovf));
        e_taken = i_valid && tk;
        e_null = i_valid && !tk && i_op inside {OP_COP_BRANCH_FALSE_LIKELY,
            OP_COP_BRANCH_TRUE_LIKELY};
        e_cop = i_cop_attached;
        e_user = i_user_attached;
        e_shadow = TOP_SET_VALUE;
    endfunction

    // Outputs against expectation
    task automatic verify();
        check(32'({o_wr_en, o_overflow}), 32'({e_wr, e_ovf}));
        check(32'({o_taken, o_nullify}), 32'({e_taken, e_null}));
        if (e_wr)
        begin
            check(32'(o_wr_idx), 32'(e_idx));
            check(o_wr_data, e_data);
        end
        if (e_taken)
            check(o_target, e_tgt);
        check(32'(o_highest_shadow_set), 32'(e_shadow));
        check(32'(o_coproc_present_flag), 32'(e_cop));
        check(32'(o_user_instr_present_flag), 32'(e_user));
    endtask

    // Main sequence: check last edge, then drive the next inputs
    initial
    begin
        void'($urandom(32'h0ecc4808));
        for (int k = 0; k < 2000; k++)
        begin
            @(negedge i_clock);
            if (i_srst)
                {e_wr, e_ovf, e_taken, e_null, e_cop, e_user, e_shadow} = '0;
            else if (i_clk_en)
                predict();
            verify();
            i_srst = (k < 11) || (k >= 1000 && k < 1003);
            i_clk_en = ($urandom_range(7) != 0);
            i_valid = ($urandom_range(5) != 0);
            i_op = iabx_op_t'($urandom_range(9));
            {i_rs, i_imm, i_offset, i_pc} = {$urandom, $urandom, $urandom, $urandom};
            i_rt_val = $urandom_range(1) ? i_rs : 32'($urandom);
            i_rs_idx = $urandom_range(3) ? 5'($urandom) : '0;
            {i_rt_idx, i_condition_select_field, i_cop_flags} = 16'($urandom);
            {i_cop_attached, i_user_attached} = 2'($urandom);
            // Register zero always reads as zero
            if (i_rs_idx == ZERO_REG)
                i_rs = '0;
            if (i_rt_idx == ZERO_REG)
                i_rt_val = '0;
            if (k >= 12 && k < 18)
            begin
                // Enum assigned alone, not through a packed concatenation
                i_op = c_op[k-12];
                {i_rs, i_imm} = {c_rs[k-12], c_imm[k-12]};
                {i_valid, i_clk_en, i_rs_idx, i_rt_idx, i_rt_val} = {2'h3, 42'h0};
            end
        end
        finish_test();
    end

    // Cuts a hang short
    initial
    begin
        #50000;
        n_errors++;
        finish_test();
    end
endmodule // tb_iabx_exec
`default_nettype wire
